// >>> rtl/ssx_alu.sv
// Combinational arithmetic for subtract and nibble swap
module ssx_alu
  import ssx_pkg::*;
(
  input  wire ssx_pkg::ssx_op_t op,
  input  wire logic [7:0]       file_val,
  input  wire logic [7:0]       acc_val,
  output logic      [7:0]       result,
  output logic                  zero,
  output logic                  digit_carry,
  output logic                  carry
);
  logic [8:0] diff_full;
  logic [4:0] diff_low;

  // Subtract as file + ~acc + 1 so carry means no borrow
  always_comb begin
    diff_full = {1'b0, file_val} + {1'b0, ~acc_val} + 9'h001;
    diff_low  = {1'b0, file_val[3:0]} + {1'b0, ~acc_val[3:0]} + 5'h01;
    carry       = diff_full[8];
    digit_carry = diff_low[4];
    if (op == SSX_OP_SWAP) begin
      result = {file_val[3:0], file_val[7:4]};
    end else begin
      result = diff_full[7:0];
    end
    zero = (result == 8'h00);
  end
endmodule

// >>> rtl/ssx_defines.svh
// Constants for the four-instruction execution block
`ifndef SSX_DEFINES_SVH
`define SSX_DEFINES_SVH
`define SSX_ADDR_CTRL      12'h000
`define SSX_ADDR_STATUS    12'h004
`define SSX_ADDR_ACC       12'h008
`define SSX_ADDR_WDOG      12'h00c
`define SSX_ADDR_FILE_BASE 12'h100
`define SSX_ADDR_SPAGE_BASE 12'h200
`define SSX_CTRL_GO_BIT    31
`define SSX_CTRL_OP_LSB    8
`define SSX_CTRL_DEST_BIT  6
`define SSX_CTRL_OPND_LSB  0
`define SSX_ST_C_BIT       0
`define SSX_ST_DC_BIT      1
`define SSX_ST_Z_BIT       2
`define SSX_ST_PD_BIT      3
`define SSX_ST_TO_BIT      4
`define SSX_ST_HALT_BIT    5
`define SSX_ST_RESET       8'h18
`define SSX_ACC_RESET      8'h00
`endif

// >>> rtl/ssx_exec.sv
// APB-reached execution unit for store, halt, subtract and swap
`include "ssx_defines.svh"

// What this block does
// - store accumulator into selected secondary register
// - halt clears watchdog counter, prescaler, halts
// - halt sets timeout flag, clears powerdown flag
// - subtract accumulator from file register, set flags
// - subtract destination bit selects accumulator or register
// - swap exchanges high and low nibbles
// - swap destination selectable, flags unchanged
module ssx_exec
  import ssx_pkg::*;
#(
  parameter int FILE_DEPTH  = 64,
  parameter int SPAGE_DEPTH = 16,
  parameter int WDOG_WIDTH  = 8,
  parameter int PRE_WIDTH   = 8
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             halted
);
  import ssx_pkg::*;

  logic [7:0]            file_q [FILE_DEPTH];
  logic [7:0]            spage_q [SPAGE_DEPTH];
  logic [7:0]            acc_q, acc_d;
  logic [7:0]            status_q, status_d;
  logic [WDOG_WIDTH-1:0] wdog_q, wdog_d;
  logic [PRE_WIDTH-1:0]  pre_q, pre_d;
  logic [31:0]           prdata_q, prdata_d;
  logic                  pready_q, pready_d;
  logic                  pslverr_q, pslverr_d;
  logic                  halted_q, halted_d;

  logic                  access;
  logic                  go;
  ssx_op_t               op;
  logic                  dest;
  logic [5:0]            opnd;
  logic [7:0]            file_val;
  logic [7:0]            alu_res;
  logic                  alu_z, alu_dc, alu_c;
  logic                  file_we;
  logic [5:0]            file_wa;
  logic [7:0]            file_wd;
  logic                  spage_we;
  logic [3:0]            spage_wa;
  logic [7:0]            spage_wd;
  logic                  do_store;
  logic                  do_halt;
  logic                  do_sub;
  logic                  do_swap;
  logic                  wr_acc;
  logic                  wr_status;
  logic                  wr_file;
  logic                  wr_spage;

  // Address window test used by several decodes
  function automatic logic in_win(input logic [11:0] a, input logic [11:0] base,
                                  input int depth);
    return (a >= base) && (a < base + 12'(depth * 4)) && (a[1:0] == 2'b00);
  endfunction

  // One wait state: pready rises in the cycle after the access is taken
  assign access = psel && penable && !pready_q;
  assign go     = access && pwrite && (paddr == `SSX_ADDR_CTRL)
                  && pwdata[`SSX_CTRL_GO_BIT];
  assign op     = ssx_op_t'(pwdata[`SSX_CTRL_OP_LSB +: 2]);
  assign dest   = pwdata[`SSX_CTRL_DEST_BIT];
  assign opnd   = pwdata[`SSX_CTRL_OPND_LSB +: 6];
  assign file_val = file_q[opnd];

  ssx_alu ssx_alu_i (
    .op          (op),
    .file_val    (file_val),
    .acc_val     (acc_q),
    .result      (alu_res),
    .zero        (alu_z),
    .digit_carry (alu_dc),
    .carry       (alu_c)
  );

  // One strobe per instruction; a halted core ignores every instruction
  always_comb begin
    do_store = 1'b0;
    do_halt  = 1'b0;
    do_sub   = 1'b0;
    do_swap  = 1'b0;
    if (go && !halted_q) begin
      case (op)
        SSX_OP_SPAGE_STORE: begin
          do_store = 1'b1;
        end
        SSX_OP_HALT: begin
          do_halt = 1'b1;
        end
        SSX_OP_SUB: begin
          do_sub = 1'b1;
        end
        SSX_OP_SWAP: begin
          do_swap = 1'b1;
        end
        default: begin
          do_store = 1'b0;
        end
      endcase
    end
  end

  // Software write strobes; go is only decoded at the CTRL word, so an
  // instruction and a direct register write never fall in one cycle
  assign wr_acc    = access && pwrite && (paddr == `SSX_ADDR_ACC);
  assign wr_status = access && pwrite && (paddr == `SSX_ADDR_STATUS);
  assign wr_file   = access && pwrite && in_win(paddr, `SSX_ADDR_FILE_BASE, FILE_DEPTH);
  assign wr_spage  = access && pwrite && in_win(paddr, `SSX_ADDR_SPAGE_BASE, SPAGE_DEPTH);

  // Accumulator: subtract or swap result with destination 0, else a
  // software write; store only reads it and halt leaves it alone
  always_comb begin
    acc_d = acc_q;
    if ((do_sub || do_swap) && !dest) begin
      acc_d = alu_res;
    end else if (wr_acc) begin
      acc_d = pwdata[7:0];
    end
  end

  // Accumulator register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= `SSX_ACC_RESET;
    end else if (clk_en) begin
      acc_q <= acc_d;
    end
  end

  // Status flags: subtract updates Z, DC and C, halt only TO and PD;
  // swap and store leave every flag alone
  always_comb begin
    status_d = status_q;
    if (do_sub) begin
      status_d[`SSX_ST_Z_BIT]  = alu_z;
      status_d[`SSX_ST_DC_BIT] = alu_dc;
      status_d[`SSX_ST_C_BIT]  = alu_c;
    end else if (do_halt) begin
      status_d[`SSX_ST_TO_BIT] = 1'b1;
      status_d[`SSX_ST_PD_BIT] = 1'b0;
    end else if (wr_status) begin
      status_d = pwdata[7:0];
    end
  end

  // Status register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= `SSX_ST_RESET;
    end else if (clk_en) begin
      status_q <= status_d;
    end
  end

  // Halt level: set by the halt instruction and cleared only by a
  // software STATUS write, as there is no wake-up logic in this block
  always_comb begin
    halted_d = halted_q;
    if (do_halt) begin
      halted_d = 1'b1;
    end else if (wr_status) begin
      halted_d = pwdata[`SSX_ST_HALT_BIT];  // Writing zero wakes the core
    end
  end

  // Halt register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halted_q <= 1'b0;
    end else if (clk_en) begin
      halted_q <= halted_d;
    end
  end

  // Watchdog: the prescaler is the low half, so the counter steps on its
  // wrap; both stop while halted, so a halt reads back as zero
  always_comb begin
    wdog_d = wdog_q;
    pre_d  = pre_q;
    if (do_halt) begin
      wdog_d = '0;
      pre_d  = '0;
    end else if (!halted_q) begin
      {wdog_d, pre_d} = {wdog_q, pre_q} + (WDOG_WIDTH + PRE_WIDTH)'(1);
    end
  end

  // Watchdog registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdog_q <= '0;
      pre_q  <= '0;
    end else if (clk_en) begin
      wdog_q <= wdog_d;
      pre_q  <= pre_d;
    end
  end

  // File write port: subtract or swap result with destination 1, else a
  // software write; the operand and the bus address share one port
  always_comb begin
    file_we = 1'b0;
    file_wa = opnd;
    file_wd = alu_res;
    if ((do_sub || do_swap) && dest) begin
      file_we = 1'b1;
    end else if (wr_file) begin
      file_we = 1'b1;
      file_wa = paddr[7:2];
      file_wd = pwdata[7:0];
    end
  end

  // Secondary-page write port: a store copies the accumulator into the
  // register picked by the low four operand bits
  always_comb begin
    spage_we = 1'b0;
    spage_wa = opnd[3:0];
    spage_wd = acc_q;
    if (do_store) begin
      spage_we = 1'b1;
    end else if (wr_spage) begin
      spage_we = 1'b1;
      spage_wa = paddr[5:2];
      spage_wd = pwdata[7:0];
    end
  end

  // Bus answer: read mux and error for unmapped words
  always_comb begin
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    pready_d  = access;
    if (access) begin
      prdata_d = 32'h0000_0000;
      if (paddr == `SSX_ADDR_CTRL) begin
        prdata_d = 32'h0000_0000;
      end else if (paddr == `SSX_ADDR_STATUS) begin
        prdata_d[7:0] = {status_q[7:6], halted_q, status_q[4:0]};
      end else if (paddr == `SSX_ADDR_ACC) begin
        prdata_d[7:0] = acc_q;
      end else if (paddr == `SSX_ADDR_WDOG) begin
        prdata_d[15:0] = {8'(pre_q), 8'(wdog_q)};
      end else if (in_win(paddr, `SSX_ADDR_FILE_BASE, FILE_DEPTH)) begin
        prdata_d[7:0] = file_q[paddr[7:2]];
      end else if (in_win(paddr, `SSX_ADDR_SPAGE_BASE, SPAGE_DEPTH)) begin
        prdata_d[7:0] = spage_q[paddr[5:2]];
      end else begin
        pslverr_d = 1'b1;
      end
    end
  end

  // Bus answer registers; clk_en low freezes a pending answer as well,
  // so the master must not stop the clock while pready is high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (clk_en) begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // File registers; no reset keeps them plain memories, so software
  // must write a register before the first instruction reads it
  always_ff @(posedge pclk) begin
    if (clk_en && file_we) begin
      file_q[file_wa] <= file_wd;
    end
  end

  // Secondary-page registers, written by a store or by software
  always_ff @(posedge pclk) begin
    if (clk_en && spage_we) begin
      spage_q[spage_wa] <= spage_wd;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign halted  = halted_q;
endmodule

// >>> rtl/ssx_pkg.sv
// Types shared by the execution block and its arithmetic unit
package ssx_pkg;
  typedef enum logic [1:0] {
    SSX_OP_SPAGE_STORE,
    SSX_OP_HALT,
    SSX_OP_SUB,
    SSX_OP_SWAP
  } ssx_op_t;
endpackage

// >>> sim/sfr_store_halt_sub_swap_exec_test.sv
// Self-checking bench for the execution block
module sfr_store_halt_sub_swap_exec_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, halted;
  logic [33:0] exp_q[$];
  logic [33:0] note;
  logic [7:0]  acc = 8'h00, fr [64], sp [16];
  logic        c = 0, dc = 0, z = 0, pd = 1, to = 1, h = 0;
  int          bad_count = 0, comparisons = 0;
  ssx_exec ssx_exec_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .halted(halted));
  initial forever #4 pclk = ~pclk;
  // Pairs each answer with the oldest note; bit 33 says whether data matters
  always @(posedge pclk) if (pready) begin
    note = exp_q.pop_front();
    comparisons++;
    if (pslverr !== note[32] || (note[33] && prdata !== note[31:0])) begin
      bad_count++;
      $display("MISMATCH prdata exp %h got %h", note[32:0], {pslverr, prdata});
    end
  end
  // One APB transfer; an idle cycle follows so psel never toggles twice in a step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [33:0] n);
    exp_q.push_back(n);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, {2'b10, e});
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 34'h0);
  endtask
  function automatic logic [31:0] st();
    return {26'h0, h, to, pd, z, dc, c};
  endfunction
  // Issues one instruction and advances the reference state; halted ignores it
  task automatic exec(input logic [1:0] op, input logic dst, input logic [5:0] r);
    logic [7:0] v;
    v = 8'h00;
    wr(12'h000, {1'b1, 21'h0, op, 1'b0, dst, r});
    if (h) return;
    case (op)
      2'd0: sp[r[3:0]] = acc;
      2'd1: {h, to, pd} = 3'b110;
      2'd2: begin
        v = fr[r] - acc;
        {c, dc, z} = {fr[r] >= acc, fr[r][3:0] >= acc[3:0], v == 8'h00};
      end
      default: v = {fr[r][3:0], fr[r][7:4]};
    endcase
    if (op > 2'd1 && dst) fr[r] = v;
    else if (op > 2'd1) acc = v;
  endtask
  // The halted pin is a level, so it is checked directly once it has settled
  task automatic check_halted();
    comparisons++;
    if (halted !== h) begin
      bad_count++;
      $display("MISMATCH halted exp %b got %b", h, halted);
    end
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #100us;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    logic [5:0] r;
    logic [1:0] op;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    void'($urandom(14));
    @(posedge pclk);
    rd(12'h004, 32'h18);
    xfer(1'b0, 12'h010, 32'h0, {2'b01, 32'h0});
    xfer(1'b1, 12'h300, 32'h5, {2'b01, 32'h0});
    for (int i = 0; i < 64; i++) begin
      fr[i] = 8'($urandom);
      wr(12'h100 + 12'(4 * i), {24'h0, fr[i]});
    end
    // Random store/subtract/swap; every fifth pass forces equal operands
    for (int i = 0; i < 40; i++) begin
      r = 6'($urandom);
      op = (i % 3 == 0) ? 2'd0 : 2'd2 + 2'(i % 2);
      acc = (i % 5 == 0) ? fr[r] : 8'($urandom);
      wr(12'h008, {24'h0, acc});
      exec(op, 1'($urandom), r);
      rd(12'h008, {24'h0, acc});
      rd(12'h004, st());
      rd(12'h100 + 12'(4 * r), {24'h0, fr[r]});
      if (op == 2'd0) rd(12'h200 + 12'(4 * r[3:0]), {24'h0, sp[r[3:0]]});
    end
    exec(2'd1, 1'b0, 6'd0);
    check_halted();
    rd(12'h004, st());
    rd(12'h00c, 32'h0);
    exec(2'd2, 1'b0, 6'd5);
    rd(12'h008, {24'h0, acc});
    h = 1'b0;
    wr(12'h004, st());
    check_halted();
    // Frozen cycles must not advance the restarted watchdog: three enabled
    // edges pass between the wake write and the read, whatever the pause
    clk_en <= 1'b0;
    repeat (2 + $urandom % 6) @(posedge pclk);
    clk_en <= 1'b1;
    rd(12'h00c, 32'h0000_0300);
    rd(12'h004, st());
    tally_and_finish();
  end
endmodule

// >>> sim/ssx_exec_properties.sv
// Port checker for the execution block, bound to its top module
module ssx_exec_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        halted
);
  logic take;
  logic st_wr;
  logic mapped;
  logic st_rd;
  // Request decode; unaligned addresses are never driven by the bench
  assign take   = psel && penable && !pready && clk_en;
  assign st_wr  = take && pwrite && paddr == 12'h004;
  assign st_rd  = take && !pwrite && paddr == 12'h004;
  assign mapped = paddr[11:4] == 8'h00 || paddr[11:8] == 4'h1 || paddr[11:6] == 6'h08;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  answer_next_a: assert property (take |=> pready) else $error("no answer");
  ready_pulse_a: assert property (pready && clk_en |=> !pready) else $error("ready too long");
  ready_cause_a: assert property ($rose(pready) |-> $past(take)) else $error("stray ready");
  err_map_a: assert property (pready |-> pslverr == !$past(mapped)) else $error("bad error");
  err_ready_a: assert property (pslverr |-> pready) else $error("error alone");
  halt_enter_a: assert property (take && pwrite && paddr == 12'h000 && pwdata[31]
    && pwdata[9:8] == 2'd1 && !halted |=> halted) else $error("no halt");
  halt_hold_a: assert property (halted && !st_wr |=> halted) else $error("halt lost");
  wake_up_a: assert property (st_wr && !pwdata[5] |=> !halted) else $error("no wake");
  halt_flags_a: assert property (pready && halted && $past(st_rd)
    |-> prdata[5:3] == 3'b110) else $error("halt flags");
endmodule

bind ssx_exec ssx_exec_properties ssx_exec_properties_i (.pclk(pclk), .presetn(presetn),
  .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .halted(halted));
